/* File: verilog/dcic_pkg.sv */
// constants, types and field layout of the two-channel input capture unit
// Behaviour
// - two 16-bit counters advance on prescale timer ticks
// - input picked among odd bits of four ports
// - pins are only observed, never driven
// - start, stop or wrap may request interrupt
// - status read clears flags and pending request
// - vector offset 0x1a0, priority 1 to 3
// - inputs sampled only on capture clock ticks
// - flag sets with its interrupt request
// - low byte read freezes high byte; read low first
// - status bits: start2 stop2 start1 stop1 roll2 roll1
// - write bits 7:4 set event interrupt enables
// - write 1 to bit 3/2 clears counter, rollover
// - control bits 11 split counter bytes, no carry
// - control, trigger and priority reset to zero
// - nonzero priority activates interrupts; set it last
// - trigger bits 3:2 start, 1:0 stop edge
// - source bits select start/stop port and bit
// - priority register low two bits, rest ignored
`default_nettype none
package dcic_pkg;
	// ==========================================
	// register offsets
	localparam logic [15:0] OFS_CTRL_STATUS = 16'h0056;
	localparam logic [15:0] OFS_IRQ_PRIORITY = 16'h0057;
	localparam logic [15:0] OFS_CH1_TRIG = 16'h0058;
	localparam logic [15:0] OFS_CH1_SRC = 16'h0059;
	localparam logic [15:0] OFS_CH1_LOW = 16'h005a;
	localparam logic [15:0] OFS_CH1_HIGH = 16'h005b;
	localparam logic [15:0] OFS_CH2_TRIG = 16'h005c;
	localparam logic [15:0] OFS_CH2_SRC = 16'h005d;
	localparam logic [15:0] OFS_CH2_LOW = 16'h005e;
	localparam logic [15:0] OFS_CH2_HIGH = 16'h005f;
	localparam logic [15:0] OFS_CH_STRIDE = 16'h0004;
	// ==========================================
	// field positions
	localparam int CS_ENABLE_LSB = 4;
	localparam int CS_FLAG_LSB = 2;
	localparam int CS_CLR_CH2 = 3;
	localparam int CS_CLR_CH1 = 2;
	localparam int TRIG_MODE_LSB = 6;
	localparam int TRIG_LATCH_LSB = 4;
	localparam int TRIG_START_LSB = 2;
	localparam int TRIG_STOP_LSB = 0;
	localparam int SRC_START_PORT_LSB = 6;
	localparam int SRC_START_BIT_LSB = 4;
	localparam int SRC_STOP_PORT_LSB = 2;
	localparam int SRC_STOP_BIT_LSB = 0;
	// ==========================================
	// reset values and codes
	localparam logic [7:0] RST_CTRL_STATUS = 8'h00;
	localparam logic [7:0] RST_TRIG = 8'h00;
	localparam logic [7:0] RST_SRC = 8'h00;
	localparam logic [1:0] RST_PRIORITY = 2'h0;
	localparam logic [1:0] TEST_SPLIT = 2'h3;
	localparam logic [11:0] VECTOR_OFFSET = 12'h1a0;
	// ==========================================
	// types
	typedef enum logic [1:0] {MODE_OFF, MODE_SPAN, MODE_FREE, MODE_UNTIL_STOP} dcic_mode_t;
	typedef enum logic [1:0] {EDGE_NONE, EDGE_RISE, EDGE_FALL, EDGE_ANY} dcic_edge_t;
	typedef enum logic [1:0] {LATCH_NONE, LATCH_STOP, LATCH_START, LATCH_EITHER} dcic_latch_t;
endpackage
`default_nettype wire

/* File: verilog/dcic_chan_if.sv */
// per-channel configuration and event signals between the register block and a channel
`default_nettype none
interface dcic_chan_if #(parameter int CW = 16);
	logic [7:0] trig;
	logic [7:0] src;
	logic test_split;
	logic cnt_clr;
	logic ev_start;
	logic ev_stop;
	logic ev_roll;
	logic [CW-1:0] hold;
	modport regs (output trig, output src, output test_split, output cnt_clr,
		input ev_start, input ev_stop, input ev_roll, input hold);
	modport chan (input trig, input src, input test_split, input cnt_clr,
		output ev_start, output ev_stop, output ev_roll, output hold);
endinterface
`default_nettype wire

/* File: verilog/dcic_channel.sv */
// one capture channel: pin select, edge detection, counter and holding register
`default_nettype none
module dcic_channel import dcic_pkg::*; #(
	parameter int CW = 16
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic cap_tick,
	input wire logic [15:0] cand,
	dcic_chan_if.chan ch
);
	// ==========================================
	// pin selection and sampling
	logic pin_start;
	logic pin_stop;
	logic smp_start;
	logic smp_stop;
	logic primed;
	logic start_hit;
	logic stop_hit;
	logic running;
	logic halted;
	logic count_en;
	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	dcic_mode_t mode;
	dcic_latch_t lsel;

	function automatic logic edge_match(input logic cur, input logic prev, input logic [1:0] sel);
		case (dcic_edge_t'(sel))
			EDGE_RISE: edge_match = cur & ~prev;
			EDGE_FALL: edge_match = ~cur & prev;
			EDGE_ANY: edge_match = cur ^ prev;
			default: edge_match = 1'b0;
		endcase
	endfunction

	// pins are read only, other functions keep driving them
	assign pin_start = cand[ch.src[SRC_START_BIT_LSB+:4]];
	assign pin_stop = cand[ch.src[SRC_STOP_BIT_LSB+:4]];

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			smp_start <= 1'b0;
			smp_stop <= 1'b0;
			primed <= 1'b0;
		end else if (cap_tick) begin
			smp_start <= pin_start;
			smp_stop <= pin_stop;
			primed <= 1'b1;
		end
	end

	assign start_hit = cap_tick & primed
		& edge_match(pin_start, smp_start, ch.trig[TRIG_START_LSB+:2]);
	assign stop_hit = cap_tick & primed
		& edge_match(pin_stop, smp_stop, ch.trig[TRIG_STOP_LSB+:2]);
	assign ch.ev_start = start_hit;
	assign ch.ev_stop = stop_hit;

	// ==========================================
	// counter
	assign mode = dcic_mode_t'(ch.trig[TRIG_MODE_LSB+:2]);
	assign lsel = dcic_latch_t'(ch.trig[TRIG_LATCH_LSB+:2]);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			running <= 1'b0;
		end else if (running) begin
			running <= ~stop_hit;
		end else begin
			running <= start_hit;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			halted <= 1'b0;
		end else if (ch.cnt_clr) begin
			halted <= 1'b0;
		end else if (stop_hit) begin
			halted <= 1'b1;
		end
	end

	always_comb begin
		case (mode)
			MODE_SPAN: count_en = cap_tick & running;
			MODE_FREE: count_en = cap_tick;
			MODE_UNTIL_STOP: count_en = cap_tick & ~halted;
			default: count_en = 1'b0;
		endcase
	end

	// split mode bumps both bytes without carry
	assign next_count = ch.test_split
		? {count[CW-1:8] + 1'b1, count[7:0] + 8'h01}
		: count + 1'b1;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
		end else if (ch.cnt_clr) begin
			count <= '0;
		end else if (count_en) begin
			count <= next_count;
		end
	end

	assign ch.ev_roll = count_en & ~ch.cnt_clr & (next_count == '0);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ch.hold <= '0;
		end else if ((stop_hit && (lsel == LATCH_STOP || lsel == LATCH_EITHER))
			|| (start_hit && (lsel == LATCH_START || lsel == LATCH_EITHER))) begin
			ch.hold <= count;
		end
	end

	// ==========================================
	// checks
	property p_clear_zero;
		@(posedge ref_clk) disable iff (!rst_n) ch.cnt_clr |=> count == '0;
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("counter not cleared");

	property p_no_carry;
		@(posedge ref_clk) disable iff (!rst_n)
		(count_en && ch.test_split && !ch.cnt_clr && count[7:0] == 8'hff)
		|=> count[7:0] == 8'h00 && count[CW-1:8] == $past(count[CW-1:8]) + 1'b1;
	endproperty
	a_no_carry: assert property (p_no_carry) else $error("split count wrong");

	property p_tick_only;
		@(posedge ref_clk) disable iff (!rst_n) !cap_tick |-> !ch.ev_start && !ch.ev_stop;
	endproperty
	a_tick_only: assert property (p_tick_only) else $error("event off a tick");

	property p_latch_stop;
		@(posedge ref_clk) disable iff (!rst_n)
		(stop_hit && lsel == LATCH_STOP) |=> ch.hold == $past(count);
	endproperty
	a_latch_stop: assert property (p_latch_stop) else $error("stop latch missed");

	property p_roll_wrap;
		@(posedge ref_clk) disable iff (!rst_n)
		(ch.ev_roll && !ch.test_split) |-> count == '1 ##1 count == '0;
	endproperty
	a_roll_wrap: assert property (p_roll_wrap) else $error("rollover without wrap");
endmodule
`default_nettype wire

/* File: verilog/dcic_top.sv */
// register block and interrupt request logic of the two-channel input capture unit
`default_nettype none
module dcic_top import dcic_pkg::*; #(
	parameter int CW = 16
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [15:0] io_addr,
	input wire logic io_rd,
	input wire logic io_wr,
	input wire logic [7:0] io_wdata,
	input wire logic [7:0] port_c,
	input wire logic [7:0] port_d,
	input wire logic [7:0] port_f,
	input wire logic [7:0] port_g,
	input wire logic cap_tick,
	output logic [7:0] io_rdata,
	output logic irq_req,
	output logic [1:0] irq_level,
	output logic [11:0] irq_vector
);
	// ==========================================
	// register state
	logic [3:0] ien;
	logic [5:0] flags;
	logic [5:0] next_flags;
	logic [5:0] ev;
	logic [1:0] test_mode;
	logic pending;
	logic next_pending;
	logic [1:0] prio;
	logic [1:0] next_prio;
	logic [7:0] trig [2];
	logic [7:0] src [2];
	logic [7:0] hi_snap [2];
	logic [CW-1:0] hold [2];
	logic [1:0] ev_start;
	logic [1:0] ev_stop;
	logic [1:0] ev_roll;
	logic [1:0] cnt_clr;
	logic [15:0] cand;
	logic cs_wr;
	logic cs_rd;
	logic req_ev;
	logic [7:0] next_rdata;

	assign cs_wr = io_wr && io_addr == OFS_CTRL_STATUS;
	assign cs_rd = io_rd && io_addr == OFS_CTRL_STATUS;

	// ==========================================
	// candidate pins: index is port code times four plus bit code
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_cand
			assign cand[gi] = port_c[2*gi+1];
			assign cand[4+gi] = port_d[2*gi+1];
			assign cand[8+gi] = port_f[2*gi+1];
			assign cand[12+gi] = port_g[2*gi+1];
		end
	endgenerate

	// ==========================================
	// channels
	generate
		for (gi = 0; gi < 2; gi++) begin : g_ch
			dcic_chan_if #(.CW(CW)) cif ();
			assign cif.trig = trig[gi];
			assign cif.src = src[gi];
			assign cif.test_split = test_mode == TEST_SPLIT;
			assign cif.cnt_clr = cnt_clr[gi];
			assign ev_start[gi] = cif.ev_start;
			assign ev_stop[gi] = cif.ev_stop;
			assign ev_roll[gi] = cif.ev_roll;
			assign hold[gi] = cif.hold;
			dcic_channel #(.CW(CW)) u_ch (
				.ref_clk(ref_clk),
				.rst_n(rst_n),
				.cap_tick(cap_tick),
				.cand(cand),
				.ch(cif.chan)
			);
		end
	endgenerate

	// ==========================================
	// configuration writes
	assign cnt_clr[0] = cs_wr && io_wdata[CS_CLR_CH1];
	assign cnt_clr[1] = cs_wr && io_wdata[CS_CLR_CH2];

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ien <= RST_CTRL_STATUS[CS_ENABLE_LSB+:4];
			test_mode <= RST_CTRL_STATUS[1:0];
		end else if (cs_wr) begin
			ien <= io_wdata[CS_ENABLE_LSB+:4];
			test_mode <= io_wdata[1:0];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			trig[0] <= RST_TRIG;
			trig[1] <= RST_TRIG;
		end else if (io_wr && io_addr == OFS_CH1_TRIG) begin
			trig[0] <= io_wdata;
		end else if (io_wr && io_addr == OFS_CH2_TRIG) begin
			trig[1] <= io_wdata;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			src[0] <= RST_SRC;
			src[1] <= RST_SRC;
		end else if (io_wr && io_addr == OFS_CH1_SRC) begin
			src[0] <= io_wdata;
		end else if (io_wr && io_addr == OFS_CH2_SRC) begin
			src[1] <= io_wdata;
		end
	end

	assign next_prio = (io_wr && io_addr == OFS_IRQ_PRIORITY) ? io_wdata[1:0] : prio;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			prio <= RST_PRIORITY;
		end else begin
			prio <= next_prio;
		end
	end

	// ==========================================
	// status flags and interrupt request
	assign ev = {ev_start[1], ev_stop[1], ev_start[0], ev_stop[0], ev_roll[1], ev_roll[0]};
	// rollover has no enable of its own and always requests
	assign req_ev = |(ev[5:2] & ien) || ev[1] || ev[0];

	always_comb begin
		next_flags = flags;
		if (cs_rd) begin
			next_flags = '0;
		end
		if (cnt_clr[0]) begin
			next_flags[0] = 1'b0;
		end
		if (cnt_clr[1]) begin
			next_flags[1] = 1'b0;
		end
		next_flags = next_flags | ev;
	end

	assign next_pending = (pending && !cs_rd) || req_ev;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			flags <= RST_CTRL_STATUS[7:CS_FLAG_LSB];
			pending <= 1'b0;
		end else begin
			flags <= next_flags;
			pending <= next_pending;
		end
	end

	// request is live as soon as priority turns nonzero
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_req <= 1'b0;
			irq_level <= RST_PRIORITY;
			irq_vector <= VECTOR_OFFSET;
		end else begin
			irq_req <= next_pending && next_prio != 2'h0;
			irq_level <= next_prio;
			irq_vector <= VECTOR_OFFSET;
		end
	end

	// ==========================================
	// reads
	always_comb begin
		case (io_addr)
			OFS_CTRL_STATUS: next_rdata = {flags, 2'h0};
			OFS_CH1_LOW: next_rdata = hold[0][7:0];
			OFS_CH1_HIGH: next_rdata = hi_snap[0];
			OFS_CH2_LOW: next_rdata = hold[1][7:0];
			OFS_CH2_HIGH: next_rdata = hi_snap[1];
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			io_rdata <= 8'h00;
		end else if (io_rd) begin
			io_rdata <= next_rdata;
		end
	end

	// low byte read freezes the matching high byte
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			hi_snap[0] <= 8'h00;
			hi_snap[1] <= 8'h00;
		end else if (io_rd && io_addr == OFS_CH1_LOW) begin
			hi_snap[0] <= hold[0][CW-1:8];
		end else if (io_rd && io_addr == OFS_CH2_LOW) begin
			hi_snap[1] <= hold[1][CW-1:8];
		end
	end

	// ==========================================
	// checks
	sequence s_status_read;
		cs_rd && ev == '0;
	endsequence

	sequence s_cleared;
		flags == '0 && !pending;
	endsequence

	property p_read_clears;
		@(posedge ref_clk) disable iff (!rst_n) s_status_read |=> s_cleared;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("status read left flags");

	property p_read_keeps_enable;
		@(posedge ref_clk) disable iff (!rst_n) (cs_rd && !cs_wr) |=> ien == $past(ien);
	endproperty
	a_read_keeps_enable: assert property (p_read_keeps_enable) else $error("enable changed");

	property p_flag_with_req;
		@(posedge ref_clk) disable iff (!rst_n)
		(ev_stop[0] && ien[0]) |=> flags[2] && pending;
	endproperty
	a_flag_with_req: assert property (p_flag_with_req) else $error("flag and request apart");

	property p_set_beats_read;
		@(posedge ref_clk) disable iff (!rst_n) (cs_rd && ev_roll[1]) |=> flags[1] && pending;
	endproperty
	a_set_beats_read: assert property (p_set_beats_read) else $error("event lost on read");

	property p_prio_gate;
		@(posedge ref_clk) disable iff (!rst_n) prio == 2'h0 |-> !irq_req;
	endproperty
	a_prio_gate: assert property (p_prio_gate) else $error("request at priority 0");

	property p_prio_live;
		@(posedge ref_clk) disable iff (!rst_n)
		(pending && next_prio != 2'h0 && !cs_rd) |=> irq_req && irq_level == $past(next_prio);
	endproperty
	a_prio_live: assert property (p_prio_live) else $error("pending not requested");

	property p_snapshot;
		@(posedge ref_clk) disable iff (!rst_n)
		(io_rd && io_addr == OFS_CH1_LOW)
		|=> hi_snap[0] == $past(hold[0][CW-1:8]) && io_rdata == $past(next_rdata);
	endproperty
	a_snapshot: assert property (p_snapshot) else $error("high byte not frozen");

	property p_status_layout;
		@(posedge ref_clk) disable iff (!rst_n) cs_rd |=> io_rdata == {$past(flags), 2'h0};
	endproperty
	a_status_layout: assert property (p_status_layout) else $error("status layout wrong");

	property p_vector;
		@(posedge ref_clk) disable iff (!rst_n) irq_req |-> irq_vector == VECTOR_OFFSET;
	endproperty
	a_vector: assert property (p_vector) else $error("vector offset wrong");

	// ==========================================
	// register and request checks
	sequence s_prio_write;
		io_wr && io_addr == OFS_IRQ_PRIORITY;
	endsequence

	property p_prio_low_bits;
		@(posedge ref_clk) disable iff (!rst_n)
		s_prio_write |=> prio == $past(io_wdata[1:0]) && irq_level == prio;
	endproperty
	a_prio_low_bits: assert property (p_prio_low_bits) else $error("priority wrong");

	property p_req_match;
		@(posedge ref_clk) disable iff (!rst_n)
		irq_req == (pending && prio != 2'h0);
	endproperty
	a_req_match: assert property (p_req_match) else $error("request mismatch");

	property p_enable_write;
		@(posedge ref_clk) disable iff (!rst_n)
		cs_wr |=> ien == $past(io_wdata[CS_ENABLE_LSB+:4]);
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable not written");

	property p_test_write;
		@(posedge ref_clk) disable iff (!rst_n)
		cs_wr |=> test_mode == $past(io_wdata[1:0]);
	endproperty
	a_test_write: assert property (p_test_write) else $error("test mode not written");

	property p_clear_roll;
		@(posedge ref_clk) disable iff (!rst_n)
		(cnt_clr != 2'b00) |=> (flags[1:0] & $past(cnt_clr)) == 2'b00;
	endproperty
	a_clear_roll: assert property (p_clear_roll) else $error("rollover not cleared");

	property p_flag_sticky;
		@(posedge ref_clk) disable iff (!rst_n)
		(!cs_rd && cnt_clr == 2'b00) |=> (flags & $past(flags)) == $past(flags);
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

	property p_event_flags;
		@(posedge ref_clk) disable iff (!rst_n)
		(ev != 6'h00) |=> (flags & $past(ev)) == $past(ev);
	endproperty
	a_event_flags: assert property (p_event_flags) else $error("event flag missing");

	property p_roll_request;
		@(posedge ref_clk) disable iff (!rst_n)
		(ev_roll != 2'b00) |=> pending;
	endproperty
	a_roll_request: assert property (p_roll_request) else $error("rollover not pending");

	property p_quiet;
		@(posedge ref_clk) disable iff (!rst_n)
		(!pending && (ev[5:2] & ien) == 4'h0 && ev[1:0] == 2'b00) |=> !pending;
	endproperty
	a_quiet: assert property (p_quiet) else $error("disabled event pending");

	property p_start2_flag;
		@(posedge ref_clk) disable iff (!rst_n)
		ev_start[1] |=> flags[5];
	endproperty
	a_start2_flag: assert property (p_start2_flag) else $error("start flag misplaced");

	property p_roll1_flag;
		@(posedge ref_clk) disable iff (!rst_n)
		ev_roll[0] |=> flags[0];
	endproperty
	a_roll1_flag: assert property (p_roll1_flag) else $error("rollover flag misplaced");

	property p_high_byte;
		@(posedge ref_clk) disable iff (!rst_n)
		(io_rd && io_addr == OFS_CH2_HIGH) |=> io_rdata == $past(hi_snap[1]);
	endproperty
	a_high_byte: assert property (p_high_byte) else $error("high byte not snapshot");

	property p_low_byte;
		@(posedge ref_clk) disable iff (!rst_n)
		(io_rd && io_addr == OFS_CH2_LOW)
		|=> io_rdata == $past(hold[1][7:0]) && hi_snap[1] == $past(hold[1][CW-1:8]);
	endproperty
	a_low_byte: assert property (p_low_byte) else $error("low byte wrong");

	property p_trig_write;
		@(posedge ref_clk) disable iff (!rst_n)
		(io_wr && io_addr == OFS_CH2_TRIG) |=> trig[1] == $past(io_wdata);
	endproperty
	a_trig_write: assert property (p_trig_write) else $error("trigger not written");

	property p_src_write;
		@(posedge ref_clk) disable iff (!rst_n)
		(io_wr && io_addr == OFS_CH1_SRC) |=> src[0] == $past(io_wdata);
	endproperty
	a_src_write: assert property (p_src_write) else $error("source not written");
endmodule
`default_nettype wire

/* File: dv/dcic_pin_model.sv */
// far-side model: capture prescale tick and the parallel port pins
`default_nettype none
module dcic_pin_model (
	input wire logic ref_clk,
	input wire logic [15:0] noise,
	output logic [7:0] port_c,
	output logic [7:0] port_d,
	output logic [7:0] port_f,
	output logic [7:0] port_g,
	output logic cap_tick
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] odd_pins = 16'h0000;
	logic [31:0] word;
	initial cap_tick = 1'b0;
	// ==========================================
	// pins
	// even pins belong to other peripherals and toggle freely
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			word[2*i] = noise[i];
			word[2*i+1] = odd_pins[i];
		end
	end
	assign port_c = word[7:0];
	assign port_d = word[15:8];
	assign port_f = word[23:16];
	assign port_g = word[31:24];
	// ==========================================
	// tick source
	// pins only move between ticks so each level is sampled once
	task automatic set_pins(input logic [15:0] v);
		odd_pins <= v;
	endtask
	task automatic pulse();
		cap_tick <= 1'b1;
		@(posedge ref_clk);
		cap_tick <= 1'b0;
		@(posedge ref_clk);
	endtask
endmodule
`default_nettype wire

/* File: dv/dual_channel_input_capture_tb_top.sv */
// self-checking bench of the two-channel input capture unit
`default_nettype none
module dual_channel_input_capture_tb_top import dcic_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk;
	logic rst_n;
	logic [15:0] io_addr;
	logic io_rd;
	logic io_wr;
	logic [7:0] io_wdata;
	logic [7:0] port_c;
	logic [7:0] port_d;
	logic [7:0] port_f;
	logic [7:0] port_g;
	logic cap_tick;
	logic [7:0] io_rdata;
	logic irq_req;
	logic [1:0] irq_level;
	logic [11:0] irq_vector;
	logic [31:0] nz;
	logic [31:0] seed;
	int fails = 0;
	int n_tests = 0;
	int cyc = 0;
	int m_cnt [2] = '{0, 0};
	int m_hold [2] = '{0, 0};
	logic [7:0] m_snap [2] = '{8'h00, 8'h00};
	logic [7:0] m_trig [2] = '{8'h00, 8'h00};
	logic [7:0] m_src [2] = '{8'h00, 8'h00};
	logic m_run [2] = '{1'b0, 1'b0};
	logic m_halt [2] = '{1'b0, 1'b0};
	logic [7:0] m_flags = 8'h00;
	logic [7:0] m_en = 8'h00;
	logic [1:0] m_test = 2'h0;
	logic [1:0] m_prio = 2'h0;
	logic m_pend = 1'b0;
	logic m_prim = 1'b0;
	logic [15:0] m_prev = 16'h0000;
	dcic_top u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .io_addr(io_addr), .io_rd(io_rd),
		.io_wr(io_wr), .io_wdata(io_wdata), .port_c(port_c), .port_d(port_d),
		.port_f(port_f), .port_g(port_g), .cap_tick(cap_tick), .io_rdata(io_rdata),
		.irq_req(irq_req), .irq_level(irq_level), .irq_vector(irq_vector));
	dcic_pin_model u_pin (.ref_clk(ref_clk), .noise(nz[15:0]), .port_c(port_c),
		.port_d(port_d), .port_f(port_f), .port_g(port_g), .cap_tick(cap_tick));
	always #20 ref_clk = ~ref_clk;
	always @(posedge ref_clk) nz <= lfsr(nz);
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			stop_test();
		end
	end
	// ==========================================
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return x[0] ? ((x >> 1) ^ 32'h80200003) : (x >> 1);
	endfunction
	function automatic logic [15:0] ofs(input logic [15:0] b, input int c);
		return b + 16'(c) * OFS_CH_STRIDE;
	endfunction
	function automatic logic hit(input logic [1:0] k, input logic p, input logic n);
		return (k[0] && !p && n) || (k[1] && p && !n);
	endfunction
	task automatic stop_test();
		if (fails == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// ==========================================
	// reference model of one capture tick
	task automatic model_tick(input logic [15:0] p);
		logic [3:0] si;
		logic [3:0] ei;
		logic st;
		logic sp;
		logic go;
		logic [1:0] md;
		for (int c = 0; c < 2; c++) begin
			si = m_src[c][7:4];
			ei = m_src[c][3:0];
			md = m_trig[c][7:6];
			st = m_prim && hit(m_trig[c][3:2], m_prev[si], p[si]);
			sp = m_prim && hit(m_trig[c][1:0], m_prev[ei], p[ei]);
			if ((m_trig[c][5] && st) || (m_trig[c][4] && sp)) m_hold[c] = m_cnt[c];
			go = md == 2'b10 || (md == 2'b01 && m_run[c]) || (md == 2'b11 && !m_halt[c]);
			if (go && m_test == TEST_SPLIT) begin
				m_cnt[c] = ((m_cnt[c] + 32'h100) & 32'hff00) | ((m_cnt[c] + 1) & 32'hff);
			end else if (go) begin
				m_cnt[c] = (m_cnt[c] + 1) & 32'hffff;
			end
			if (go && m_cnt[c] == 0) m_flags[2+c] = 1'b1;
			if (go && m_cnt[c] == 0) m_pend = 1'b1;
			m_run[c] = m_run[c] ? !sp : st;
			if (sp) m_halt[c] = 1'b1;
			if (st) m_flags[5+2*c] = 1'b1;
			if (sp) m_flags[4+2*c] = 1'b1;
			if ((st && m_en[5+2*c]) || (sp && m_en[4+2*c])) m_pend = 1'b1;
		end
		m_prev = p;
		m_prim = 1'b1;
	endtask
	// ==========================================
	// bus and tick drivers
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		io_addr <= a;
		io_wdata <= d;
		io_wr <= 1'b1;
		@(posedge ref_clk);
		io_wr <= 1'b0;
		@(posedge ref_clk);
		if (a == OFS_CTRL_STATUS) begin
			m_en = d;
			m_test = d[1:0];
			for (int c = 0; c < 2; c++) begin
				if (d[2+c]) begin
					m_cnt[c] = 0;
					m_halt[c] = 1'b0;
					m_flags[2+c] = 1'b0;
				end
			end
		end
		if (a == OFS_IRQ_PRIORITY) m_prio = d[1:0];
		for (int c = 0; c < 2; c++) begin
			if (a == ofs(OFS_CH1_TRIG, c)) m_trig[c] = d;
			if (a == ofs(OFS_CH1_SRC, c)) m_src[c] = d;
		end
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		io_addr <= a;
		io_rd <= 1'b1;
		@(posedge ref_clk);
		io_rd <= 1'b0;
		@(posedge ref_clk);
		d = io_rdata;
	endtask
	task automatic rchk(input logic [15:0] a);
		logic [7:0] d;
		logic [7:0] e;
		e = 8'h00;
		if (a == OFS_CTRL_STATUS) begin
			e = {m_flags[7:2], 2'b00};
			m_flags = 8'h00;
			m_pend = 1'b0;
		end
		for (int c = 0; c < 2; c++) begin
			if (a == ofs(OFS_CH1_LOW, c)) e = m_hold[c][7:0];
			if (a == ofs(OFS_CH1_LOW, c)) m_snap[c] = m_hold[c][15:8];
			if (a == ofs(OFS_CH1_HIGH, c)) e = m_snap[c];
		end
		rd(a, d);
		check("io_rdata", {8'h00, d}, {8'h00, e});
	endtask
	task automatic tick(input logic [15:0] p);
		u_pin.set_pins(p);
		@(posedge ref_clk);
		model_tick(p);
		u_pin.pulse();
		@(posedge ref_clk);
		check("irq_req", {15'h0, irq_req}, {15'h0, m_pend && m_prio != 2'h0});
	endtask
	task automatic near(input int c);
		logic [7:0] lo;
		logic [7:0] hi;
		rd(ofs(OFS_CH1_LOW, c), lo);
		rd(ofs(OFS_CH1_HIGH, c), hi);
		m_snap[c] = m_hold[c][15:8];
		check("hold", {hi, lo}, m_hold[c][15:0]);
	endtask
	// ==========================================
	// main sequence
	initial begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		io_addr = 16'h0000;
		io_rd = 1'b0;
		io_wr = 1'b0;
		io_wdata = 8'h00;
		nz = 32'd97825;
		seed = 32'd97825;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		check("irq_vector", {4'h0, irq_vector}, 16'h01a0);
		check("irq_level", {14'h0, irq_level}, 16'h0000);
		rchk(OFS_CTRL_STATUS);
		rchk(16'h0060);
		rchk(OFS_CH1_TRIG);
		for (int p = 0; p < 4; p++) begin
			wr(OFS_IRQ_PRIORITY, {6'h2b, 2'(p)});
			check("irq_level", {14'h0, irq_level}, 16'(p));
		end
		tick(16'hffff);
		for (int it = 0; it < 12; it++) begin
			tick(16'h0000);
			for (int c = 0; c < 2; c++) begin
				seed = lfsr(seed);
				wr(ofs(OFS_CH1_TRIG, c), {seed[7] ? 2'b10 : 2'b00, seed[5:0]});
				wr(ofs(OFS_CH1_SRC, c), seed[15:8]);
			end
			seed = lfsr(seed);
			wr(OFS_CTRL_STATUS, {seed[7:4], 2'b11, seed[1:0]});
			rchk(OFS_CTRL_STATUS);
			wr(OFS_IRQ_PRIORITY, seed[15:8]);
			repeat (6) begin
				seed = lfsr(seed);
				tick(seed[15:0]);
			end
			rchk(OFS_CTRL_STATUS);
			for (int c = 0; c < 2; c++) begin
				rchk(ofs(OFS_CH1_LOW, c));
				rchk(ofs(OFS_CH1_HIGH, c));
			end
		end
		tick(16'h0000);
		wr(OFS_CH1_SRC, 8'h00);
		wr(OFS_CH1_TRIG, 8'ha4);
		wr(OFS_CH2_TRIG, 8'h00);
		wr(OFS_CTRL_STATUS, 8'h07);
		wr(OFS_IRQ_PRIORITY, 8'h01);
		rchk(OFS_CTRL_STATUS);
		repeat (3) tick(16'h0000);
		tick(16'h0001);
		rchk(OFS_CH1_LOW);
		tick(16'h0000);
		tick(16'h0001);
		rchk(OFS_CH1_HIGH);
		rchk(OFS_CH1_LOW);
		rchk(OFS_CH1_HIGH);
		repeat (256) tick(16'h0000);
		rchk(OFS_CTRL_STATUS);
		repeat (256) tick(16'h0000);
		wr(OFS_CTRL_STATUS, 8'h07);
		rchk(OFS_CTRL_STATUS);
		tick(16'h0000);
		wr(OFS_CH2_SRC, 8'hff);
		wr(OFS_CH2_TRIG, 8'h56);
		wr(OFS_CTRL_STATUS, 8'h08);
		repeat (2) tick(16'h0000);
		repeat (6) tick(16'h8000);
		tick(16'h0000);
		near(1);
		wr(OFS_CH2_TRIG, 8'hf6);
		wr(OFS_CTRL_STATUS, 8'h08);
		repeat (3) tick(16'h0000);
		tick(16'h8000);
		rchk(OFS_CH2_LOW);
		rchk(OFS_CH2_HIGH);
		repeat (2) tick(16'h8000);
		tick(16'h0000);
		rchk(OFS_CH2_LOW);
		rchk(OFS_CH2_HIGH);
		repeat (2) tick(16'h0000);
		tick(16'h8000);
		near(1);
		stop_test();
	end
endmodule
`default_nettype wire
